// ==== rtl/irqdf_freeze_reg.sv ====
// Debug freeze control register storage with write decode.
module irqdf_freeze_reg
    import irqdf_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    input  wire irqdf_req_s                 req,
    output logic     [IRQDF_FRZ_WIDTH-1:0]  ctrl_r
);

    logic hit;
    assign hit = req.sel && req.wr && (req.addr == IRQDF_FREEZE_ADDR);

    // Reserved bits are not stored, so they always read back as zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= IRQDF_FREEZE_RESET[IRQDF_FRZ_WIDTH-1:0];
        end else if (ce && hit) begin
            ctrl_r <= req.wdata[IRQDF_FRZ_WIDTH-1:0];
        end
    end

endmodule : irqdf_freeze_reg

// ==== rtl/irqdf_pkg.sv ====
// Package of constants and carrier types for the interrupt map and debug freeze block.
package irqdf_pkg;

    localparam int unsigned IRQDF_NUM_LINES  = 80;
    localparam int unsigned IRQDF_NUM_XFER   = 16;
    localparam int unsigned IRQDF_NUM_PORT   = 12;
    localparam int unsigned IRQDF_NUM_EXT    = 8;
    localparam int unsigned IRQDF_FRZ_WIDTH  = 3;

    // Debug freeze control register.
    localparam logic [31:0] IRQDF_FREEZE_ADDR  = 32'hE0042000;
    localparam logic [31:0] IRQDF_FREEZE_RESET = 32'h00000000;
    localparam int unsigned IRQDF_FRZ_WDT_BIT  = 0;
    localparam int unsigned IRQDF_FRZ_AST_BIT  = 1;
    localparam int unsigned IRQDF_FRZ_EVC_BIT  = 2;

    // Interrupt line numbers at the core's interrupt controller.
    localparam int unsigned IRQDF_LINE_FLASH   = 0;
    localparam int unsigned IRQDF_LINE_XFER0   = 1;
    localparam int unsigned IRQDF_LINE_SYS0    = 17;
    localparam int unsigned IRQDF_LINE_PORT0   = 25;
    localparam int unsigned IRQDF_LINE_BKP_PWR = 37;
    localparam int unsigned IRQDF_LINE_BKP_SYS = 38;
    localparam int unsigned IRQDF_LINE_TMR0    = 39;
    localparam int unsigned IRQDF_LINE_WDT     = 44;
    localparam int unsigned IRQDF_LINE_EXT0    = 45;
    localparam int unsigned IRQDF_LINE_AUDIO   = 53;
    localparam int unsigned IRQDF_LINE_SPI     = 54;
    localparam int unsigned IRQDF_LINE_TC0     = 55;
    localparam int unsigned IRQDF_LINE_TWI0    = 61;
    localparam int unsigned IRQDF_LINE_SER0    = 65;
    localparam int unsigned IRQDF_LINE_ANA0    = 69;
    localparam int unsigned IRQDF_LINE_SPARE   = 76;
    localparam int unsigned IRQDF_LINE_TWM2    = 77;
    localparam int unsigned IRQDF_LINE_LCD     = 79;

    // Peripheral request sources; every field is an active-high level.
    typedef struct packed {
        logic                        flash_ctrl_irq;
        logic [IRQDF_NUM_XFER-1:0]   periph_xfer_channel_irq;
        logic                        crc_unit_irq;
        logic                        usb_iface_irq;
        logic                        event_trigger_irq;
        logic                        event_overrun_irq;
        logic                        crypto_engine_irq;
        logic                        power_manager_irq;
        logic                        sys_ctrl_iface_irq;
        logic                        freq_meter_irq;
        logic [IRQDF_NUM_PORT-1:0]   port_ctrl_irq;
        logic                        backup_power_irq;
        logic                        backup_sys_ctrl_irq;
        logic [4:0]                  async_timer_irq;
        logic                        watchdog_irq;
        logic [IRQDF_NUM_EXT-1:0]    ext_int_irq;
        logic                        serial_audio_irq;
        logic                        spi_irq;
        logic [5:0]                  timer_ch_irq;
        logic [3:0]                  two_wire_irq;
        logic [3:0]                  serial_port_irq;
        logic                        adc_iface_irq;
        logic                        dac_ctrl_irq;
        logic                        comparator_irq;
        logic                        audio_bitstream_irq;
        logic                        random_gen_irq;
        logic                        parallel_capture_irq;
        logic                        touch_sense_irq;
        logic                        two_wire_master2_irq;
        logic                        two_wire_master3_irq;
        logic                        lcd_ctrl_irq;
    } irqdf_src_s;

    // Register access port request.
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } irqdf_req_s;

endpackage : irqdf_pkg

// ==== rtl/irqdf_top.sv ====
// Interrupt line map toward the core and debug freeze control for asynchronous peripherals.
//
// Functional notes
// - Line 0 carries the flash request and lines 1 to 16 carry transfer channels 0 to 15 in order.
// - Lines 17 to 24 carry CRC, USB, event trigger, event overrun, crypto, power, system control, frequency meter.
// - Lines 25 to 36 carry port requests 0 to 11, 37 backup power, 38 backup control, 39 to 43 timer, 44 watchdog.
// - Lines 45 to 52 carry external requests 0 to 7, 53 audio, 54 SPI, 55 to 60 timer channels, 61 to 64 two-wire.
// - Lines 65 to 68 carry serial ports, 69 to 75 the analog and misc group, 77 and 78 two-wire 2 and 3, 79 LCD.
// - The 32-bit debug freeze register at 0xE0042000 is read/write, resets to zero, bits 31 to 3 read zero.
// - Bit 0 set freezes the watchdog counter while in debug with the core halted.
// - Bit 1 set freezes the async timer prescaler and counter while in debug with the core halted.
// - Bit 2 set freezes the event controller while in debug with the core halted.
// - A clear freeze bit lets its peripheral run during debug whether or not the core is halted.
module irqdf_top
    import irqdf_pkg::*;
#(
    parameter int unsigned NUM_LINES = IRQDF_NUM_LINES
) (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire irqdf_src_s            src,
    input  wire logic                  debug_active,
    input  wire logic                  core_halted,
    input  wire irqdf_req_s            req,
    output logic     [NUM_LINES-1:0]   irq_lines_r,
    output logic     [31:0]            rdata_r,
    output logic                       ack_r,
    output logic                       watchdog_freeze_r,
    output logic                       async_timer_freeze_r,
    output logic                       event_controller_freeze_r
);

    // Elaboration-time refusal: fewer lines than the map needs would silently drop sources.
    if (NUM_LINES < IRQDF_NUM_LINES) begin : g_lines_check
        $error("NUM_LINES too small for the interrupt map");
    end

    // Builds the line vector from the sources; unused lines stay low.
    function automatic logic [NUM_LINES-1:0] map_lines(input irqdf_src_s s);
        logic [NUM_LINES-1:0] v;
        v = '0;
        v[IRQDF_LINE_FLASH] = s.flash_ctrl_irq;
        for (int i = 0; i < IRQDF_NUM_XFER; i++) begin
            v[IRQDF_LINE_XFER0+i] = s.periph_xfer_channel_irq[i];
        end
        v[IRQDF_LINE_SYS0+0] = s.crc_unit_irq;
        v[IRQDF_LINE_SYS0+1] = s.usb_iface_irq;
        v[IRQDF_LINE_SYS0+2] = s.event_trigger_irq;
        v[IRQDF_LINE_SYS0+3] = s.event_overrun_irq;
        v[IRQDF_LINE_SYS0+4] = s.crypto_engine_irq;
        v[IRQDF_LINE_SYS0+5] = s.power_manager_irq;
        v[IRQDF_LINE_SYS0+6] = s.sys_ctrl_iface_irq;
        v[IRQDF_LINE_SYS0+7] = s.freq_meter_irq;
        for (int i = 0; i < IRQDF_NUM_PORT; i++) begin
            v[IRQDF_LINE_PORT0+i] = s.port_ctrl_irq[i];
        end
        v[IRQDF_LINE_BKP_PWR] = s.backup_power_irq;
        v[IRQDF_LINE_BKP_SYS] = s.backup_sys_ctrl_irq;
        for (int i = 0; i < 5; i++) begin
            v[IRQDF_LINE_TMR0+i] = s.async_timer_irq[i];
        end
        v[IRQDF_LINE_WDT] = s.watchdog_irq;
        for (int i = 0; i < IRQDF_NUM_EXT; i++) begin
            v[IRQDF_LINE_EXT0+i] = s.ext_int_irq[i];
        end
        v[IRQDF_LINE_AUDIO] = s.serial_audio_irq;
        v[IRQDF_LINE_SPI]   = s.spi_irq;
        for (int i = 0; i < 6; i++) begin
            v[IRQDF_LINE_TC0+i] = s.timer_ch_irq[i];
        end
        for (int i = 0; i < 4; i++) begin
            v[IRQDF_LINE_TWI0+i] = s.two_wire_irq[i];
            v[IRQDF_LINE_SER0+i] = s.serial_port_irq[i];
        end
        v[IRQDF_LINE_ANA0+0] = s.adc_iface_irq;
        v[IRQDF_LINE_ANA0+1] = s.dac_ctrl_irq;
        v[IRQDF_LINE_ANA0+2] = s.comparator_irq;
        v[IRQDF_LINE_ANA0+3] = s.audio_bitstream_irq;
        v[IRQDF_LINE_ANA0+4] = s.random_gen_irq;
        v[IRQDF_LINE_ANA0+5] = s.parallel_capture_irq;
        v[IRQDF_LINE_ANA0+6] = s.touch_sense_irq;
        v[IRQDF_LINE_SPARE]  = 1'b0;
        v[IRQDF_LINE_TWM2]   = s.two_wire_master2_irq;
        v[IRQDF_LINE_TWM2+1] = s.two_wire_master3_irq;
        v[IRQDF_LINE_LCD]    = s.lcd_ctrl_irq;
        return v;
    endfunction : map_lines

    logic [IRQDF_FRZ_WIDTH-1:0] ctrl_r;
    logic                       halted_dbg;
    logic                       rd_hit;

    irqdf_freeze_reg u_freeze_reg (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .req     (req),
        .ctrl_r  (ctrl_r)
    );

    assign halted_dbg = debug_active && core_halted;
    assign rd_hit     = req.addr == IRQDF_FREEZE_ADDR;

    // A register stage keeps every line glitch-free at the core at the cost of one cycle of latency.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_lines_r <= '0;
        end else if (ce) begin
            irq_lines_r <= map_lines(src);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            watchdog_freeze_r         <= 1'b0;
            async_timer_freeze_r      <= 1'b0;
            event_controller_freeze_r <= 1'b0;
        end else if (ce) begin
            watchdog_freeze_r         <= ctrl_r[IRQDF_FRZ_WDT_BIT] && halted_dbg;
            async_timer_freeze_r      <= ctrl_r[IRQDF_FRZ_AST_BIT] && halted_dbg;
            event_controller_freeze_r <= ctrl_r[IRQDF_FRZ_EVC_BIT] && halted_dbg;
        end
    end

    // Reads answer one cycle later; an unmapped address reads as zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else if (ce) begin
            ack_r <= req.sel;
            if (req.sel && !req.wr && rd_hit) begin
                rdata_r <= {{(32-IRQDF_FRZ_WIDTH){1'b0}}, ctrl_r};
            end else begin
                rdata_r <= '0;
            end
        end
    end

    property p_flash_xfer;
        @(posedge clk_sys) disable iff (!resetn)
        ce |=> irq_lines_r[16:0] == {$past(src.periph_xfer_channel_irq), $past(src.flash_ctrl_irq)};
    endproperty
    a_flash_xfer: assert property (p_flash_xfer) else $error("flash or transfer line mismatch");

    property p_sys_group;
        @(posedge clk_sys) disable iff (!resetn)
        ce |=> irq_lines_r[24:17] == {$past(src.freq_meter_irq), $past(src.sys_ctrl_iface_irq),
                                      $past(src.power_manager_irq), $past(src.crypto_engine_irq),
                                      $past(src.event_overrun_irq), $past(src.event_trigger_irq),
                                      $past(src.usb_iface_irq), $past(src.crc_unit_irq)};
    endproperty
    a_sys_group: assert property (p_sys_group) else $error("system group line mismatch");

    property p_port_timer;
        @(posedge clk_sys) disable iff (!resetn)
        ce |=> irq_lines_r[44:25] == {$past(src.watchdog_irq), $past(src.async_timer_irq),
                                      $past(src.backup_sys_ctrl_irq), $past(src.backup_power_irq),
                                      $past(src.port_ctrl_irq)};
    endproperty
    a_port_timer: assert property (p_port_timer) else $error("port or timer line mismatch");

    property p_ext_tc;
        @(posedge clk_sys) disable iff (!resetn)
        ce |=> irq_lines_r[64:45] == {$past(src.two_wire_irq), $past(src.timer_ch_irq), $past(src.spi_irq),
                                      $past(src.serial_audio_irq), $past(src.ext_int_irq)};
    endproperty
    a_ext_tc: assert property (p_ext_tc) else $error("external or timer channel line mismatch");

    property p_upper;
        @(posedge clk_sys) disable iff (!resetn)
        ce |=> irq_lines_r[79:77] == {$past(src.lcd_ctrl_irq), $past(src.two_wire_master3_irq),
                                      $past(src.two_wire_master2_irq)}
               && irq_lines_r[68:65] == $past(src.serial_port_irq)
               && irq_lines_r[75] == $past(src.touch_sense_irq) && irq_lines_r[69] == $past(src.adc_iface_irq);
    endproperty
    a_upper: assert property (p_upper) else $error("upper line mismatch");

    property p_spare;
        @(posedge clk_sys) disable iff (!resetn)
        !irq_lines_r[IRQDF_LINE_SPARE];
    endproperty
    a_spare: assert property (p_spare) else $error("spare line raised");

    property p_reg_rw;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && req.sel && req.wr && rd_hit) ##1 (ce && req.sel && !req.wr && rd_hit)
        |=> ack_r && rdata_r == {29'h0000000, $past(req.wdata[2:0], 2)};
    endproperty
    a_reg_rw: assert property (p_reg_rw) else $error("freeze register readback wrong");

    property p_wdt_freeze;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && ctrl_r[IRQDF_FRZ_WDT_BIT] && debug_active && core_halted) |=> watchdog_freeze_r;
    endproperty
    a_wdt_freeze: assert property (p_wdt_freeze) else $error("watchdog not frozen");

    property p_ast_freeze;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && ctrl_r[IRQDF_FRZ_AST_BIT] && debug_active && core_halted) |=> async_timer_freeze_r;
    endproperty
    a_ast_freeze: assert property (p_ast_freeze) else $error("async timer not frozen");

    property p_evc_freeze;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && ctrl_r[IRQDF_FRZ_EVC_BIT] && debug_active && core_halted) |=> event_controller_freeze_r;
    endproperty
    a_evc_freeze: assert property (p_evc_freeze) else $error("event controller not frozen");

    property p_no_freeze;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && (!ctrl_r[IRQDF_FRZ_WDT_BIT] || !debug_active || !core_halted)) |=> !watchdog_freeze_r;
    endproperty
    a_no_freeze: assert property (p_no_freeze) else $error("watchdog frozen without cause");

    property p_no_freeze_ast;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && (!ctrl_r[IRQDF_FRZ_AST_BIT] || !debug_active || !core_halted)) |=> !async_timer_freeze_r;
    endproperty
    a_no_freeze_ast: assert property (p_no_freeze_ast) else $error("async timer frozen without cause");

    property p_no_freeze_evc;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && (!ctrl_r[IRQDF_FRZ_EVC_BIT] || !debug_active || !core_halted)) |=> !event_controller_freeze_r;
    endproperty
    a_no_freeze_evc: assert property (p_no_freeze_evc) else $error("event controller frozen without cause");

endmodule : irqdf_top

// ==== tb/irq_map_debug_freeze_tb_top.sv ====
// Self-checking bench for the interrupt map and debug freeze block.
module irq_map_debug_freeze_tb_top import irqdf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [79:0] irq;
        logic [2:0]  frz;
        logic        ack;
        logic [31:0] rdata;
    } irqdf_exp_s;

    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        ce = 1'b1;
    irqdf_src_s  src = '0;
    irqdf_req_s  req = '0;
    logic        dbg_cmd = 1'b0;
    logic        halt_cmd = 1'b0;
    logic        slow = 1'b0;
    logic        debug_active;
    logic        core_halted;
    logic        ack_r;
    logic [79:0] irq_lines_r;
    logic [31:0] rdata_r;
    logic [2:0]  frz;
    irqdf_exp_s  exp_q[$];
    irqdf_exp_s  last = '0;
    logic [2:0]  ctrl_m = '0;
    integer      seed = 10;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;

    initial forever #20 clk_sys = ~clk_sys;

    irqdf_top #(.NUM_LINES(80)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .src(src), .debug_active(debug_active),
        .core_halted(core_halted), .req(req), .irq_lines_r(irq_lines_r), .rdata_r(rdata_r), .ack_r(ack_r),
        .watchdog_freeze_r(frz[0]), .async_timer_freeze_r(frz[1]), .event_controller_freeze_r(frz[2])
    );

    irqdf_core_model core (
        .clk_sys(clk_sys), .resetn(resetn), .dbg_cmd(dbg_cmd), .halt_cmd(halt_cmd), .slow(slow),
        .debug_active(debug_active), .core_halted(core_halted)
    );

    function automatic logic [79:0] map(input irqdf_src_s s);
        return {s.lcd_ctrl_irq, s.two_wire_master3_irq, s.two_wire_master2_irq, 1'b0, s.touch_sense_irq,
                s.parallel_capture_irq, s.random_gen_irq, s.audio_bitstream_irq, s.comparator_irq,
                s.dac_ctrl_irq, s.adc_iface_irq, s.serial_port_irq, s.two_wire_irq, s.timer_ch_irq, s.spi_irq,
                s.serial_audio_irq, s.ext_int_irq, s.watchdog_irq, s.async_timer_irq, s.backup_sys_ctrl_irq,
                s.backup_power_irq, s.port_ctrl_irq, s.freq_meter_irq, s.sys_ctrl_iface_irq,
                s.power_manager_irq, s.crypto_engine_irq, s.event_overrun_irq, s.event_trigger_irq,
                s.usb_iface_irq, s.crc_unit_irq, s.periph_xfer_channel_irq, s.flash_ctrl_irq};
    endfunction : map

    task automatic check(input string name, input logic [79:0] seen, input logic [79:0] expv);
        num_checks++;
        if (seen !== expv) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, expv, seen);
        end
    endtask : check

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // Notes the expected outputs of the coming edge, then drives the inputs for it.
    task automatic step(input irqdf_req_s r, input logic c, input irqdf_src_s s);
        irqdf_exp_s e;
        @(negedge clk_sys);
        e = last;
        if (c) begin
            e.irq = map(s);
            e.frz = ctrl_m & {3{debug_active & core_halted}};
            e.ack = r.sel;
            e.rdata = (r.sel && !r.wr && r.addr == IRQDF_FREEZE_ADDR) ? {29'h0, ctrl_m} : 32'h0;
            if (r.sel && r.wr && r.addr == IRQDF_FREEZE_ADDR) ctrl_m = r.wdata[2:0];
        end
        exp_q.push_back(e);
        last = e;
        req = r;
        ce = c;
        src = s;
    endtask : step

    always @(posedge clk_sys) begin
        irqdf_exp_s e;
        #1;
        if (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check("irq_lines", irq_lines_r, e.irq);
            check("watchdog_freeze", frz[0], e.frz[0]);
            check("async_timer_freeze", frz[1], e.frz[1]);
            check("event_controller_freeze", frz[2], e.frz[2]);
            check("ack", ack_r, e.ack);
            if (e.ack) check("rdata", rdata_r, e.rdata);
        end
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        irqdf_req_s  r;
        irqdf_src_s  s;
        logic [95:0] rnd;
        irqdf_req_s  tbl[7];
        tbl = '{'{1'b1, 1'b0, IRQDF_FREEZE_ADDR, 32'h0}, '{1'b1, 1'b1, IRQDF_FREEZE_ADDR, 32'hFFFFFFFF},
                '{1'b1, 1'b0, IRQDF_FREEZE_ADDR, 32'h0}, '{1'b1, 1'b1, IRQDF_FREEZE_ADDR + 32'h4, 32'h0},
                '{1'b1, 1'b0, IRQDF_FREEZE_ADDR, 32'h0}, '{1'b1, 1'b1, IRQDF_FREEZE_ADDR, 32'h5},
                '{1'b1, 1'b0, IRQDF_FREEZE_ADDR + 32'h4, 32'h0}};
        repeat (12) @(negedge clk_sys);
        resetn = 1'b1;
        // One source at a time, so a swapped or shifted line shows up by itself.
        for (int i = 0; i < $bits(irqdf_src_s); i++) begin
            s = '0;
            s[i] = 1'b1;
            step('0, 1'b1, s);
        end
        $display("test line map done");
        for (int i = 0; i < 7; i++) step(tbl[i], 1'b1, '0);
        $display("test freeze register done");
        for (int i = 0; i < 400; i++) begin
            rnd = {$random(seed), $random(seed), $random(seed)};
            r.sel = rnd[80];
            r.wr = rnd[81];
            r.addr = rnd[82] ? IRQDF_FREEZE_ADDR : IRQDF_FREEZE_ADDR ^ {24'h0, rnd[95:88]};
            r.wdata = $random(seed);
            step(r, |rnd[86:84], irqdf_src_s'(rnd[$bits(irqdf_src_s)-1:0]));
            dbg_cmd = rnd[83] | rnd[79];
            halt_cmd = rnd[87] | rnd[88];
            slow = rnd[89];
        end
        $display("test random freeze and map done");
        // Mid-run reset: all outputs clear at once and the register reads back its reset value.
        @(negedge clk_sys);
        resetn = 1'b0;
        ctrl_m = '0;
        #1;
        check("irq_lines_in_reset", irq_lines_r, '0);
        check("freeze_in_reset", frz, '0);
        check("ack_in_reset", ack_r, '0);
        check("rdata_in_reset", rdata_r, '0);
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        step(tbl[0], 1'b1, '0);
        $display("test mid-run reset done");
        step('0, 1'b1, '0);
        repeat (2) @(posedge clk_sys);
        #2;
        end_sim();
    end
endmodule : irq_map_debug_freeze_tb_top

// ==== tb/irqdf_core_model.sv ====
// Behavioural model of the core's debug halt logic that feeds the freeze inputs.
module irqdf_core_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic dbg_cmd,
    input  wire logic halt_cmd,
    input  wire logic slow,
    output logic      debug_active,
    output logic      core_halted
);
    timeunit 1ns;
    timeprecision 1ps;

    logic halt_d_r;

    // A slow core takes one extra cycle to report the halt, and it can only halt while in debug.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            debug_active <= 1'b0;
            halt_d_r     <= 1'b0;
            core_halted  <= 1'b0;
        end else begin
            debug_active <= dbg_cmd;
            halt_d_r     <= halt_cmd & dbg_cmd;
            core_halted  <= slow ? halt_d_r & dbg_cmd : halt_cmd & dbg_cmd;
        end
    end
endmodule : irqdf_core_model
